// *** rtl/icp_pkg.sv ***
// Shared constants, types and helper functions of the instruction pipeline.
package icp_pkg;

   localparam int PC_W = 12;
   localparam int IW = 16;
   localparam int DW = 8;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [IW-1:0] IR_RESET = 16'h0000;
   localparam logic [DW-1:0] ACC_RESET = 8'h00;
   // Core cycles per phase while the slow oscillator drives the core.
   localparam int SLOW_DIV = 8;
   localparam logic [2:0] SLOW_LAST = 3'(SLOW_DIV - 1);
   localparam logic [PC_W-1:0] PC_STEP = 12'h001;

   ////////////////////////////////////////////////////////////////////////
   // Instruction word: [15:12] opcode, [11:9] function, [8] indirect,
   // [7:0] immediate, [1:0] memory address, [11:0] branch target.
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_ALUI = 4'h1;
   localparam logic [3:0] OP_ALUM = 4'h2;
   localparam logic [3:0] OP_MOVM = 4'h3;
   localparam logic [3:0] OP_JMP = 4'h4;
   localparam logic [3:0] OP_CALL = 4'h5;
   localparam logic [3:0] OP_SZ = 4'h6;
   localparam logic [3:0] OP_LALUI = 4'h8;

   localparam logic [2:0] ALU_ADD = 3'h0;
   localparam logic [2:0] ALU_SUB = 3'h1;
   localparam logic [2:0] ALU_AND = 3'h2;
   localparam logic [2:0] ALU_OR = 3'h3;
   localparam logic [2:0] ALU_XOR = 3'h4;
   localparam logic [2:0] ALU_ROL = 3'h5;
   localparam logic [2:0] ALU_INC = 3'h6;
   localparam logic [2:0] ALU_DEC = 3'h7;

   // Data memory map: two general bytes, then the mapped registers.
   localparam logic [1:0] MEM_GPR1 = 2'h1;
   localparam logic [1:0] MEM_PCL = 2'h2;
   localparam logic [1:0] MEM_ACC = 2'h3;

   typedef struct packed {
      logic p1;
      logic p2;
      logic p3;
      logic p4;
   } icp_phase_type;

   typedef struct packed {
      logic rd;
      logic [PC_W-1:0] addr;
   } icp_pm_req_type;

   typedef struct packed {
      logic [3:0] op;
      logic [2:0] func;
      logic ind;
      logic [1:0] maddr;
      logic [DW-1:0] imm;
      logic [PC_W-1:0] target;
   } icp_instr_type;

   function automatic icp_instr_type icp_decode(input logic [IW-1:0] w);
      icp_instr_type r;
      r.op = w[15:12];
      r.func = w[11:9];
      r.ind = w[8];
      r.maddr = w[1:0];
      r.imm = w[7:0];
      r.target = w[11:0];
      return r;
   endfunction : icp_decode

   // Result bit 8 is carry, or borrow for subtract and decrement.
   function automatic logic [DW:0] icp_alu(input logic [2:0] f,
                                           input logic [DW-1:0] a,
                                           input logic [DW-1:0] b);
      logic [DW:0] r;
      r = {1'b0, a};
      unique case (f)
         ALU_ADD: r = {1'b0, a} + {1'b0, b};
         ALU_SUB: r = {1'b0, a} - {1'b0, b};
         ALU_AND: r = {1'b0, a & b};
         ALU_OR: r = {1'b0, a | b};
         ALU_XOR: r = {1'b0, a ^ b};
         ALU_ROL: r = {a[DW-1], a[DW-2:0], a[DW-1]};
         ALU_INC: r = {1'b0, a} + 9'h001;
         ALU_DEC: r = {1'b0, a} - 9'h001;
      endcase
      return r;
   endfunction : icp_alu

endpackage : icp_pkg

// *** rtl/icp_phase_gen.sv ***
// Four-phase generator with fast or slow oscillator rate selection.
`timescale 1ns/1ps
module icp_phase_gen import icp_pkg::*; (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic osc_slow_sel_i,
   output logic tick_o,
   output icp_phase_type phase_o
);

   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR}
      icp_phase_state_type;

   icp_phase_state_type state_q, state_d;
   logic [2:0] cnt_q, cnt_d;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      // RQ9 oscillator source select
      tick_o = !osc_slow_sel_i || (cnt_q == SLOW_LAST);
      cnt_d = tick_o ? 3'h0 : 3'(cnt_q + 3'h1);
      state_d = state_q;
      // RQ1 four phase sequence
      if (tick_o) begin
         unique case (state_q)
            PH_ONE: state_d = PH_TWO;
            PH_TWO: state_d = PH_THREE;
            PH_THREE: state_d = PH_FOUR;
            PH_FOUR: state_d = PH_ONE;
         endcase
      end
      phase_o = '{p1: state_q == PH_ONE, p2: state_q == PH_TWO,
                  p3: state_q == PH_THREE, p4: state_q == PH_FOUR};
   end

   // RQ13 reset holds phase one
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= PH_ONE;
         cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   phase_wrap_a: assert property (@(posedge core_clk_i) // RQ1
      disable iff (!rst_b_i) tick_o && phase_o.p4 |=> phase_o.p1)
      else $error("phase four not followed by phase one");
   slow_rate_a: assert property (@(posedge core_clk_i) // RQ9
      disable iff (!rst_b_i)
      osc_slow_sel_i && tick_o ##1 osc_slow_sel_i |-> !tick_o)
      else $error("slow oscillator advanced phase on consecutive cycles");
   slow_osc_c: cover property (@(posedge core_clk_i)
      disable iff (!rst_b_i) osc_slow_sel_i && tick_o && phase_o.p4);

endmodule : icp_phase_gen

// *** rtl/icp_pipeline.sv ***
// Instruction fetch and execute sequencer of the 8-bit core.
//
// Behaviour
// RQ1: Four non-overlapping phases; one pass through them is one cycle.
// RQ2: Phase one advances the program counter and fetches the next word.
// RQ3: Phases two to four decode and execute the current instruction.
// RQ4: Fetch overlaps execute; standard takes one cycle, extended two.
// RQ5: Instructions changing the program counter take one extra cycle.
// RQ6: Branch uses one cycle for its target, the next to transfer control.
// RQ7: 8-bit ALU does arithmetic, logic, rotate, inc, dec and tests.
// RQ8: Accumulator and ALU carry data; mapped registers direct or indirect.
// RQ9: Phase clock comes from the fast or slow internal RC oscillator.
// RQ10: A taken skip discards the prefetched word and inserts a dummy cycle.
// RQ11: Writing the low program counter byte jumps in-page with a dummy cycle.
// RQ12: After reset execution starts at program address zero.
// RQ13: Reset holds the phase generator so phase one comes first.
`timescale 1ns/1ps
module icp_pipeline import icp_pkg::*; (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic osc_slow_sel_i,
   input wire logic [IW-1:0] pm_data_i,
   output icp_pm_req_type pm_req_o,
   output icp_phase_type phase_o,
   output logic tick_o,
   output logic [PC_W-1:0] pc_o,
   output logic [DW-1:0] acc_o,
   output logic zero_o,
   output logic carry_o,
   output logic dummy_cycle_o,
   output logic retire_o
);

   logic tick;
   icp_phase_type phase;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [IW-1:0] fetch_ir_q, fetch_ir_d;
   logic [IW-1:0] exec_ir_q, exec_ir_d;
   logic exec_vld_q, exec_vld_d;
   logic ext_second_q, ext_second_d;
   logic [DW-1:0] acc_q, acc_d;
   logic z_q, z_d;
   logic c_q, c_d;
   logic [DW-1:0] gpr_q [2];
   logic [DW-1:0] gpr_d [2];
   icp_instr_type ins;
   logic fetch_en;
   logic commit;
   logic last;
   logic retire;
   logic flush;
   logic [1:0] ea;
   logic [DW-1:0] alu_b;
   logic [DW:0] alu_res;

   icp_phase_gen u_phase (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .osc_slow_sel_i(osc_slow_sel_i),
      .tick_o(tick),
      .phase_o(phase)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      ins = icp_decode(exec_ir_q);
      // RQ8 indirect address from byte zero
      ea = ins.ind ? gpr_q[0][1:0] : ins.maddr;
      unique case (ea)
         MEM_PCL: alu_b = pc_q[DW-1:0];
         MEM_ACC: alu_b = acc_q;
         default: alu_b = gpr_q[ea[0]];
      endcase
      if (ins.op != OP_ALUM) begin
         alu_b = ins.imm;
      end
      // RQ7 shared 8-bit ALU
      alu_res = icp_alu(ins.func, acc_q, alu_b);

      // RQ2 fetch and increment in phase one
      fetch_en = tick && phase.p1 && !ext_second_q;
      // RQ3 results commit at the end of phase four
      commit = tick && phase.p4;
      // RQ4 extended instructions hold the slot for a second cycle
      last = !(exec_vld_q && ins.op == OP_LALUI && !ext_second_q);
      retire = commit && exec_vld_q && last;

      pc_d = pc_q;
      fetch_ir_d = fetch_ir_q;
      exec_ir_d = exec_ir_q;
      exec_vld_d = exec_vld_q;
      ext_second_d = ext_second_q;
      acc_d = acc_q;
      z_d = z_q;
      c_d = c_q;
      gpr_d = gpr_q;
      flush = 1'b0;

      if (fetch_en) begin
         fetch_ir_d = pm_data_i;
         pc_d = pc_q + PC_STEP;
      end

      if (commit && !last) begin
         ext_second_d = 1'b1;
      end

      if (retire) begin
         ext_second_d = 1'b0;
         unique case (ins.op)
            OP_ALUI, OP_ALUM, OP_LALUI: begin
               acc_d = alu_res[DW-1:0];
               c_d = alu_res[DW];
               z_d = (alu_res[DW-1:0] == ACC_RESET);
            end
            OP_MOVM: begin
               // RQ11 page-local jump through the low byte
               if (ea == MEM_PCL) begin
                  pc_d = {pc_q[PC_W-1:DW], acc_q};
                  flush = 1'b1;
               end else if (ea != MEM_ACC) begin
                  gpr_d[ea[0]] = acc_q;
               end
            end
            // RQ6 target taken now, transfer next cycle
            OP_JMP, OP_CALL: begin
               pc_d = ins.target;
               flush = 1'b1;
            end
            // RQ10 taken skip drops the prefetched word
            OP_SZ: begin
               flush = (acc_q == ACC_RESET);
            end
            default: begin
            end
         endcase
      end

      // RQ5 a flushed slot becomes the extra dummy cycle
      if (commit && last) begin
         exec_ir_d = fetch_ir_q;
         exec_vld_d = !flush;
      end
   end

   // RQ12 execution starts at address zero
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_q <= PC_RESET;
         fetch_ir_q <= IR_RESET;
         exec_ir_q <= IR_RESET;
         exec_vld_q <= 1'b0;
         ext_second_q <= 1'b0;
         acc_q <= ACC_RESET;
         z_q <= 1'b0;
         c_q <= 1'b0;
         gpr_q <= '{default: ACC_RESET};
      end else begin
         pc_q <= pc_d;
         fetch_ir_q <= fetch_ir_d;
         exec_ir_q <= exec_ir_d;
         exec_vld_q <= exec_vld_d;
         ext_second_q <= ext_second_d;
         acc_q <= acc_d;
         z_q <= z_d;
         c_q <= c_d;
         gpr_q <= gpr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      pm_req_o.rd = fetch_en;
      pm_req_o.addr = pc_q;
      phase_o = phase;
      tick_o = tick;
      pc_o = pc_q;
      acc_o = acc_q;
      zero_o = z_q;
      carry_o = c_q;
      dummy_cycle_o = !exec_vld_q;
      retire_o = retire;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking icp_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   phase_onehot_a: assert property ($onehot(phase)) // RQ1
      else $error("phase is not one-hot");
   fetch_phase_a: assert property (pm_req_o.rd |-> phase.p1 && tick) // RQ2
      else $error("fetch outside phase one");
   // In fast mode the strobe already shows in reset, so the release edge must not count.
   pc_increment_a: assert property ( // RQ2
      rst_b_i && pm_req_o.rd |=> pc_q == 12'($past(pc_q) + PC_STEP))
      else $error("program counter did not advance on fetch");
   exec_phase_a: assert property (retire |-> phase.p4 && tick) // RQ3
      else $error("instruction retired outside phase four");
   ext_two_a: assert property ( // RQ4
      commit && exec_vld_q && ins.op == OP_LALUI && !ext_second_q
      |-> !retire ##1 (ext_second_q && !pm_req_o.rd) [*4])
      else $error("extended instruction did not hold its slot");
   alu_add_a: assert property ( // RQ7
      retire && ins.op == OP_ALUI && ins.func == ALU_ADD
      |=> acc_q == 8'($past(acc_q) + $past(alu_b)))
      else $error("accumulator add result wrong");
   branch_two_a: assert property ( // RQ6
      retire && (ins.op == OP_JMP || ins.op == OP_CALL)
      |=> pc_q == $past(ins.target) && dummy_cycle_o)
      else $error("branch target or dummy slot missing");
   skip_dummy_a: assert property ( // RQ10
      retire && ins.op == OP_SZ && acc_q == ACC_RESET
      |=> dummy_cycle_o && $stable(pc_q))
      else $error("taken skip did not insert dummy cycle");
   pcl_page_a: assert property ( // RQ11
      retire && ins.op == OP_MOVM && ea == MEM_PCL
      |=> pc_q[PC_W-1:DW] == $past(pc_q[PC_W-1:DW])
          && pc_q[DW-1:0] == $past(acc_q) && dummy_cycle_o)
      else $error("low byte write left the page or kept the slot");
   reset_start_a: assert property ( // RQ12
      $rose(rst_b_i) |-> pc_q == PC_RESET && phase.p1 && dummy_cycle_o)
      else $error("reset did not start at address zero");

   jump_c: cover property (retire && ins.op == OP_JMP ##1 dummy_cycle_o);
   skip_c: cover property (retire && ins.op == OP_SZ && flush);
   ext_c: cover property (retire && ins.op == OP_LALUI);
   pcl_c: cover property (retire && ins.op == OP_MOVM && ea == MEM_PCL);

endmodule : icp_pipeline

// *** verification/icp_prog_mem.sv ***
// Behavioural program memory that answers fetches in the same cycle.
`timescale 1ns/1ps
module icp_prog_mem import icp_pkg::*; (
   input wire logic core_clk_i,
   input icp_pm_req_type pm_req_i,
   output logic [IW-1:0] pm_data_o
);
   logic [IW-1:0] mem [0:255];
   logic [IW-1:0] junk_q = 16'h5a3c;

   // Outside a fetch the bus shows a moving pattern, never the last word.
   always @(posedge core_clk_i) begin
      junk_q <= {junk_q[14:0], ~junk_q[15]};
   end

   assign pm_data_o = pm_req_i.rd ? mem[pm_req_i.addr[7:0]] : junk_q;
endmodule : icp_prog_mem

// *** verification/tb_instruction_cycle_pipeline.sv ***
// Self-checking bench for the instruction fetch and execute sequencer.
`timescale 1ns/1ps
module tb_instruction_cycle_pipeline import icp_pkg::*;;
   typedef struct {logic [DW:0] ca; int gap;} icp_exp_type;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic osc_slow_sel_i = 1'b0;
   logic [IW-1:0] pm_data;
   icp_pm_req_type pm_req;
   icp_phase_type phase;
   logic retire;
   logic [DW-1:0] acc;
   logic tick;
   logic [PC_W-1:0] pc;
   logic zero;
   logic carry;
   logic dummy;
   icp_exp_type exp_q[$];
   icp_exp_type e;
   int n_mismatch = 0;
   int compares = 0;
   int clk_n = 0;

   icp_pipeline dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .osc_slow_sel_i(osc_slow_sel_i), .pm_data_i(pm_data),
      .pm_req_o(pm_req), .phase_o(phase), .tick_o(tick), .pc_o(pc),
      .acc_o(acc), .zero_o(zero), .carry_o(carry),
      .dummy_cycle_o(dummy), .retire_o(retire));
   icp_prog_mem mem_u (.core_clk_i(core_clk_i), .pm_req_i(pm_req),
      .pm_data_o(pm_data));

   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] ex, input logic [15:0] got);
      compares++;
      if (got !== ex) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
      end
   endtask : chk

   task end_sim;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // Bit 8 is carry, or borrow for subtract and decrement.
   function automatic logic [8:0] alu_ref(input int f, input logic [7:0] a,
                                          input logic [7:0] b);
      case (f)
         0: return {1'b0, a} + {1'b0, b};
         1: return {1'b0, a} - {1'b0, b};
         2: return {1'b0, a & b};
         3: return {1'b0, a | b};
         4: return {1'b0, a ^ b};
         5: return {a[7], a[6:0], a[7]};
         6: return {1'b0, a} + 9'h001;
         default: return {1'b0, a} - 9'h001;
      endcase
   endfunction : alu_ref

   // Places a word and notes carry, accumulator and cycle gap of its retire.
   task put(input int ad, input logic [15:0] w, input logic [8:0] ca,
            input int g);
      mem_u.mem[ad] = w;
      exp_q.push_back('{ca, g});
   endtask : put

   ////////////////////////////////////////////////////////////////////////
   // The gap is counted in clocks; zero means the first retire, unchecked.
   always @(negedge core_clk_i) begin
      if (rst_b_i !== 1'b1) begin
         clk_n = 0;
      end else begin
         clk_n++;
         if (retire === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.gap != 0) begin
               chk("retire gap", 16'(e.gap), 16'(clk_n));
            end
            clk_n = 0;
            @(posedge core_clk_i);
            #1;
            chk("accumulator", 16'(e.ca[7:0]), 16'(acc));
            chk("carry", 16'(e.ca[8]), 16'(carry));
            chk("zero", 16'(e.ca[7:0] == 8'h00), 16'(zero));
         end
      end
   end

   task run_prog(input logic slow);
      int k;
      int c;
      logic [8:0] a;
      logic [7:0] imm;
      @(posedge core_clk_i);
      rst_b_i <= 1'b0;
      osc_slow_sel_i <= slow;
      c = slow ? 4 * SLOW_DIV : 4;
      for (k = 0; k < 256; k++) mem_u.mem[k] = 16'h0000;
      a = 9'h000;
      for (k = 0; k < 8; k++) begin
         imm = 8'($urandom);
         a = alu_ref(k, a[7:0], imm);
         put(k, {OP_ALUI, 3'(k), 1'b0, imm}, a, k == 0 ? 0 : c);
      end
      put(8, {OP_JMP, 12'h010}, a, c);
      mem_u.mem[9] = {OP_ALUI, ALU_ADD, 1'b0, 8'hff};
      put(16, {OP_ALUI, ALU_AND, 1'b0, 8'h00}, 9'h000, 2 * c);
      put(17, {OP_SZ, 12'h000}, 9'h000, c);
      mem_u.mem[18] = {OP_ALUI, ALU_ADD, 1'b0, 8'h11};
      put(19, {OP_LALUI, ALU_ADD, 1'b0, 8'h22}, 9'h022, 3 * c);
      put(20, {OP_ALUI, ALU_ADD, 1'b0, 8'h20}, 9'h042, c);
      put(21, {OP_MOVM, 3'h0, 1'b0, 8'h02}, 9'h042, c);
      mem_u.mem[22] = {OP_ALUI, ALU_ADD, 1'b0, 8'h01};
      put(66, {OP_ALUI, ALU_ADD, 1'b0, 8'h01}, 9'h043, 2 * c);
      put(67, {OP_MOVM, 3'h0, 1'b0, 8'h00}, 9'h043, c);
      put(68, {OP_ALUM, ALU_ADD, 1'b1, 8'h00}, 9'h086, c);
      put(69, {OP_ALUM, ALU_XOR, 1'b0, 8'h03}, 9'h000, c);
      put(70, {OP_CALL, 12'h048}, 9'h000, c);
      mem_u.mem[71] = {OP_ALUI, ALU_ADD, 1'b0, 8'hff};
      put(72, {OP_NOP, 12'h000}, 9'h000, 2 * c);
      mem_u.mem[73] = {OP_JMP, 12'h049};
      repeat (10) @(posedge core_clk_i);
      #1;
      chk("phase in reset", 16'h0008, 16'(phase));
      @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      k = 0;
      do begin
         @(negedge core_clk_i);
         k++;
      end while (pm_req.rd !== 1'b1 && k < 40);
      chk("first fetch address", 16'h0000, 16'(pm_req.addr));
      chk("program counter", 16'h0000, 16'(pc));
      chk("fetch tick", 16'h0001, 16'(tick));
      chk("first slot dummy", 16'h0001, 16'(dummy));
      k = 0;
      while (exp_q.size() > 0 && k < 3000) begin
         @(posedge core_clk_i);
         k++;
      end
      chk("notes left", 16'h0000, 16'(exp_q.size()));
      repeat (4) @(posedge core_clk_i);
   endtask : run_prog

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(14));
      run_prog(1'b0);
      $display("Fast source program test done");
      run_prog(1'b1);
      $display("Slow source program test done");
      end_sim();
   end

   initial begin
      #(25 * 20000);
      n_mismatch++;
      $display("Watchdog expired before the tests ended");
      end_sim();
   end
endmodule : tb_instruction_cycle_pipeline
